// file: common/adc_i2c_pkg.sv
// Shared constants and state types for the I2C converter front end
`default_nettype none
package adc_i2c_pkg;
  // Clock rates
  localparam int CLK_HZ = 50_000_000;
  localparam int SCL_MAX_HZ = 3_400_000;
  // Command byte field positions
  localparam int CMD_INPUT_MODE_BIT = 7;
  localparam int CMD_CHAN_HI_BIT = 6;
  localparam int CMD_CHAN_MID_BIT = 5;
  localparam int CMD_CHAN_LO_BIT = 4;
  localparam int CMD_REF_PWR_BIT = 3;
  localparam int CMD_CONV_PWR_BIT = 2;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // Result word
  localparam int RES_BITS = 10;
  localparam logic [RES_BITS-1:0] RESULT_RESET = 10'h000;
  localparam logic [RES_BITS-1:0] SAR_FIRST = 10'h200;
  // Converter power-up time, rounded up to whole clock cycles
  localparam int PWRUP_NS = 1400;
  localparam int PWRUP_CYC = (PWRUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SAMPLE_CYC = 4;
  localparam int SAR_PHASES = 3;
  localparam int WAIT_W = 7;
  // Link and converter states
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ADDR_ACK, L_WR, L_WR_ACK, L_RD, L_RD_ACK, L_SKIP} link_state_t;
  typedef enum logic [1:0] {C_IDLE, C_WAIT, C_SAR} conv_state_t;
endpackage : adc_i2c_pkg
`default_nettype wire

// file: rtl/adc_i2c_front.sv
// I2C slave front end and conversion sequencer of a 10-bit SAR converter
`default_nettype none
// Behaviour
// - Upper five address bits match fixed code.
// - Next two bits match latched select pins.
// - Last address bit: 1 read, 0 write.
// - Acknowledge a fully matching address byte.
// - Acknowledge every received byte; honour START/STOP.
// - Shift results out; release SDA after NACK.
// - SDA fall/rise with SCL high: START/STOP.
// - SDA changes only while SCL low.
// - Acknowledger holds SDA low through ninth pulse.
// - Repeated START begins the next transfer.
// - Slave works at SCL up to 3.4MHz.
// - Command byte: mode, channel, power bits.
// - Mode bit 0 differential, 1 single-ended.
// - Power bits select reference and converter power.
// - Differential: low bits pair, high bit polarity.
// - Single-ended: pair plus member, negative is common.
// - Four-channel build accepts channels 0-3 only.
// - Core clock off when idle and unaddressed.
// - Straight binary code, step is Vref/1024.
// - Command byte powers converter and starts conversion.
// - Result as two bytes, zero padded.
// - Reference off after power-on.
// - Reference on at STOP/Sr; cleared bit turns off.
module adc_i2c_front #(
  parameter int CHANNELS = 8,
  parameter logic [4:0] FIXED_CODE = 5'h0B // Arbitrary value
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADDR_SELECT_PIN_HI,
  input wire logic ADDR_SELECT_PIN_LO,
  input wire logic COMP_HI,
  output logic [adc_i2c_pkg::RES_BITS-1:0] DAC_CODE,
  output logic [2:0] MUX_POS,
  output logic [2:0] MUX_NEG,
  output logic NEG_IS_COM,
  output logic SAMPLE,
  output logic CONV_CLK_EN,
  output logic CONV_POWER,
  output logic REF_POWER,
  output logic CONV_BUSY
);
  generate
    if (CHANNELS != 4 && CHANNELS != 8) begin : g_bad_channels
      $error("CHANNELS must be 4 or 8");
    end
  endgenerate

  localparam int RB = adc_i2c_pkg::RES_BITS;
  localparam int WAIT_W = adc_i2c_pkg::WAIT_W;

  // ---------------- Link side, clocked by SCL ----------------
  logic start_det_r;
  logic stop_det_r;
  logic start_ack_r;
  adc_i2c_pkg::link_state_t lstate_r;
  adc_i2c_pkg::link_state_t lstate_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] cnt_nxt;
  logic [6:0] shift_r;
  logic rw_r;
  logic [7:0] cmd_r;
  logic cmd_tog_r;
  logic byte_sel_r;
  logic addressed_r;
  logic busy_r;
  logic sda_low_r;
  logic sel_hi_r;
  logic sel_lo_r;
  logic [RB-1:0] result_hold_r;

  // START flag: SDA falling while SCL high; cleared once the first bit is taken
  wire start_clr_n = RESETN & ~start_ack_r;
  always_ff @(negedge SDA_IN or negedge start_clr_n) begin
    if (!start_clr_n) begin
      start_det_r <= 1'b0;
    end else if (SCL) begin
      start_det_r <= 1'b1;
    end
  end

  // STOP flag: SDA rising while SCL high; a new START clears it
  wire stop_clr_n = RESETN & ~start_det_r;
  always_ff @(posedge SDA_IN or negedge stop_clr_n) begin
    if (!stop_clr_n) begin
      stop_det_r <= 1'b0;
    end else if (SCL) begin
      stop_det_r <= 1'b1;
    end
  end

  // Byte decode; data is sampled on the rising SCL edge only, so SDA moves are ignored in high phases
  wire last_bit = (bit_cnt_r == 3'h7);
  wire [7:0] rx_byte = {shift_r, SDA_IN};
  wire code_match = (rx_byte[7:3] == FIXED_CODE);
  wire sel_match = (rx_byte[2:1] == {sel_hi_r, sel_lo_r});
  wire addr_match = code_match & sel_match;
  wire addr_take = (lstate_r == adc_i2c_pkg::L_ADDR) & last_bit & ~start_det_r;
  wire cmd_take = (lstate_r == adc_i2c_pkg::L_WR) & last_bit & ~start_det_r;
  wire [7:0] tx_byte = byte_sel_r ? {result_hold_r[5:0], 2'b00} : {4'h0, result_hold_r[9:6]};
  wire ack_phase = (lstate_r == adc_i2c_pkg::L_ADDR_ACK) | (lstate_r == adc_i2c_pkg::L_WR_ACK);
  wire tx_low = (lstate_r == adc_i2c_pkg::L_RD) & ~tx_byte[~bit_cnt_r];

  // Next link state; a START overrides whatever transfer was under way
  always_comb begin
    lstate_nxt = lstate_r;
    cnt_nxt = bit_cnt_r + 3'h1;
    if (start_det_r) begin
      lstate_nxt = adc_i2c_pkg::L_ADDR;
      cnt_nxt = 3'h1;
    end else begin
      unique case (lstate_r)
        adc_i2c_pkg::L_IDLE, adc_i2c_pkg::L_SKIP: begin
          cnt_nxt = 3'h0;
        end
        adc_i2c_pkg::L_ADDR: begin
          if (last_bit) begin
            lstate_nxt = addr_match ? adc_i2c_pkg::L_ADDR_ACK : adc_i2c_pkg::L_SKIP;
          end
        end
        adc_i2c_pkg::L_ADDR_ACK: begin
          cnt_nxt = 3'h0;
          lstate_nxt = rw_r ? adc_i2c_pkg::L_RD : adc_i2c_pkg::L_WR;
        end
        adc_i2c_pkg::L_WR: begin
          if (last_bit) begin
            lstate_nxt = adc_i2c_pkg::L_WR_ACK;
          end
        end
        adc_i2c_pkg::L_WR_ACK: begin
          cnt_nxt = 3'h0;
          lstate_nxt = adc_i2c_pkg::L_WR;
        end
        adc_i2c_pkg::L_RD: begin
          if (last_bit) begin
            lstate_nxt = adc_i2c_pkg::L_RD_ACK;
          end
        end
        adc_i2c_pkg::L_RD_ACK: begin
          cnt_nxt = 3'h0;
          lstate_nxt = SDA_IN ? adc_i2c_pkg::L_SKIP : adc_i2c_pkg::L_RD;
        end
      endcase
    end
  end

  wire addr_nxt = (lstate_nxt != adc_i2c_pkg::L_IDLE) & (lstate_nxt != adc_i2c_pkg::L_SKIP) &
                  (lstate_nxt != adc_i2c_pkg::L_ADDR);

  // Receive side on rising SCL; plain edge-clocked logic keeps up with 3.4MHz SCL
  always_ff @(posedge SCL or negedge RESETN) begin
    if (!RESETN) begin
      lstate_r <= adc_i2c_pkg::L_IDLE;
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
      rw_r <= 1'b0;
      start_ack_r <= 1'b0;
      cmd_r <= adc_i2c_pkg::CMD_RESET;
      cmd_tog_r <= 1'b0;
      byte_sel_r <= 1'b0;
      addressed_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      start_ack_r <= start_det_r;
      lstate_r <= lstate_nxt;
      bit_cnt_r <= cnt_nxt;
      shift_r <= rx_byte[6:0];
      addressed_r <= addr_nxt;
      busy_r <= (lstate_nxt != adc_i2c_pkg::L_IDLE) & (lstate_nxt != adc_i2c_pkg::L_SKIP);
      if (addr_take) begin
        rw_r <= SDA_IN;
      end
      if (cmd_take) begin
        cmd_r <= rx_byte;
        cmd_tog_r <= ~cmd_tog_r;
      end
      // Result bytes alternate for as long as the master keeps reading
      if (lstate_r == adc_i2c_pkg::L_ADDR_ACK) begin
        byte_sel_r <= 1'b0;
      end else if (lstate_r == adc_i2c_pkg::L_RD_ACK) begin
        byte_sel_r <= ~byte_sel_r;
      end
    end
  end

  // Drive side on falling SCL, so SDA only moves while SCL is low
  always_ff @(negedge SCL or negedge RESETN) begin
    if (!RESETN) begin
      sda_low_r <= 1'b0;
    end else begin
      sda_low_r <= ack_phase | tx_low;
    end
  end

  // Open drain: only ever pull low, otherwise release (covers NACK release)
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_low_r;

  // ---------------- Core side, clocked by CLK ----------------
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [1:0] strap_cnt_r;
  logic tog_seen_r;
  logic bound_seen_r;
  logic pend_r;
  logic [7:0] cmd_hold_r;
  logic [7:0] mode_r;
  logic ref_req_r;
  logic ref_on_r;
  adc_i2c_pkg::conv_state_t cstate_r;
  logic [adc_i2c_pkg::WAIT_W-1:0] wait_r;
  logic [1:0] phase_r;
  logic [RB-1:0] sar_r;
  logic [RB-1:0] mask_r;
  logic [RB-1:0] result_r;
  logic powered_r;

  // Two-flop synchronisers for pins and link-side levels
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= {ADDR_SELECT_PIN_HI, ADDR_SELECT_PIN_LO, COMP_HI, start_det_r, stop_det_r,
                  addressed_r, busy_r, cmd_tog_r};
      sync2_r <= sync1_r;
    end
  end

  wire s_pin_hi = sync2_r[7];
  wire s_pin_lo = sync2_r[6];
  wire s_comp = sync2_r[5];
  wire s_start = sync2_r[4];
  wire s_stop = sync2_r[3];
  wire s_addr = sync2_r[2] & ~s_stop;
  wire s_busy = sync2_r[1];
  wire s_tog = sync2_r[0];
  wire bound = s_start | s_stop;
  wire bound_evt = bound & ~bound_seen_r;
  wire cmd_evt = s_tog ^ tog_seen_r;
  wire hold_chan_ok = (CHANNELS == 8) | ~cmd_hold_r[adc_i2c_pkg::CMD_CHAN_MID_BIT];
  wire start_conv = pend_r & (cstate_r == adc_i2c_pkg::C_IDLE);

  // Select straps are taken until the third edge, once the synchroniser holds real pin levels
  // They stay static afterwards, so the link can read them without a handshake
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      strap_cnt_r <= 2'h0;
      sel_hi_r <= 1'b0;
      sel_lo_r <= 1'b0;
    end else if (strap_cnt_r != 2'h3) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      sel_hi_r <= s_pin_hi;
      sel_lo_r <= s_pin_lo;
    end
  end

  // Command intake and reference control
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tog_seen_r <= 1'b0;
      bound_seen_r <= 1'b0;
      pend_r <= 1'b0;
      cmd_hold_r <= adc_i2c_pkg::CMD_RESET;
      ref_req_r <= 1'b0;
      ref_on_r <= 1'b0;
    end else begin
      tog_seen_r <= s_tog;
      bound_seen_r <= bound;
      if (cmd_evt) begin
        // Link holds cmd_r for a whole byte after the toggle, so it is stable here
        cmd_hold_r <= cmd_r;
        pend_r <= 1'b1;
        ref_req_r <= cmd_r[adc_i2c_pkg::CMD_REF_PWR_BIT];
        if (!cmd_r[adc_i2c_pkg::CMD_REF_PWR_BIT]) begin
          ref_on_r <= 1'b0;
        end
      end else begin
        if (start_conv) begin
          pend_r <= 1'b0;
        end
        if (bound_evt && ref_req_r) begin
          ref_on_r <= 1'b1;
        end
      end
    end
  end

  wire [RB-1:0] sar_keep = s_comp ? sar_r : (sar_r & ~mask_r);
  wire wait_done = (wait_r == '0);

  // Conversion sequencer: power-up wait or, when already powered, acquisition, then one bit per SAR_PHASES cycles
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cstate_r <= adc_i2c_pkg::C_IDLE;
      wait_r <= '0;
      phase_r <= 2'h0;
      sar_r <= adc_i2c_pkg::RESULT_RESET;
      mask_r <= adc_i2c_pkg::RESULT_RESET;
      result_r <= adc_i2c_pkg::RESULT_RESET;
      mode_r <= adc_i2c_pkg::CMD_RESET;
      powered_r <= 1'b0;
    end else begin
      unique case (cstate_r)
        adc_i2c_pkg::C_IDLE: begin
          if (start_conv && hold_chan_ok) begin
            mode_r <= cmd_hold_r;
            cstate_r <= adc_i2c_pkg::C_WAIT;
            wait_r <= powered_r ? WAIT_W'(adc_i2c_pkg::SAMPLE_CYC) :
                      WAIT_W'(adc_i2c_pkg::PWRUP_CYC);
          end
        end
        adc_i2c_pkg::C_WAIT: begin
          if (wait_done) begin
            cstate_r <= adc_i2c_pkg::C_SAR;
            sar_r <= adc_i2c_pkg::SAR_FIRST;
            mask_r <= adc_i2c_pkg::SAR_FIRST;
            phase_r <= 2'h0;
          end else begin
            wait_r <= wait_r - WAIT_W'(1);
          end
        end
        adc_i2c_pkg::C_SAR: begin
          // Two cycles of comparator synchroniser latency before each decision
          if (phase_r == 2'(adc_i2c_pkg::SAR_PHASES - 1)) begin
            phase_r <= 2'h0;
            sar_r <= sar_keep | (mask_r >> 1);
            mask_r <= mask_r >> 1;
            if (mask_r[0]) begin
              result_r <= sar_keep;
              cstate_r <= adc_i2c_pkg::C_IDLE;
            end
          end else begin
            phase_r <= phase_r + 2'h1;
          end
        end
      endcase
      // Converter stays powered between conversions only when its power bit is set
      if (cstate_r == adc_i2c_pkg::C_IDLE) begin
        powered_r <= mode_r[adc_i2c_pkg::CMD_CONV_PWR_BIT];
      end else begin
        powered_r <= 1'b1;
      end
    end
  end

  // Result handed to the link only while no transfer is in flight, so bytes never tear
  // Link state freezes at STOP since SCL stops, so a seen STOP also ends the transfer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      result_hold_r <= adc_i2c_pkg::RESULT_RESET;
    end else if (!(s_start || (s_busy && !s_stop))) begin
      result_hold_r <= result_r;
    end
  end

  // Mux: pair index from low bits, member from high bit; negative is partner or common
  assign MUX_POS = {mode_r[adc_i2c_pkg::CMD_CHAN_MID_BIT], mode_r[adc_i2c_pkg::CMD_CHAN_LO_BIT],
                    mode_r[adc_i2c_pkg::CMD_CHAN_HI_BIT]};
  assign MUX_NEG = {mode_r[adc_i2c_pkg::CMD_CHAN_MID_BIT], mode_r[adc_i2c_pkg::CMD_CHAN_LO_BIT],
                    ~mode_r[adc_i2c_pkg::CMD_CHAN_HI_BIT]};
  assign NEG_IS_COM = mode_r[adc_i2c_pkg::CMD_INPUT_MODE_BIT];

  // Analog control outputs
  assign DAC_CODE = sar_r;
  assign SAMPLE = (cstate_r == adc_i2c_pkg::C_WAIT);
  assign CONV_BUSY = (cstate_r != adc_i2c_pkg::C_IDLE);
  assign CONV_CLK_EN = CONV_BUSY | s_addr;
  assign CONV_POWER = powered_r | CONV_BUSY;
  assign REF_POWER = ref_on_r;

  // ---------------- Assertions ----------------
  property p_addr_decide;
    @(posedge SCL) disable iff (!RESETN)
      addr_take |=> ((lstate_r == adc_i2c_pkg::L_ADDR_ACK) == $past(addr_match));
  endproperty
  a_addr_decide: assert property (p_addr_decide) else $error("address match decision wrong");

  property p_sel_pins;
    @(posedge SCL) disable iff (!RESETN)
      (addr_take && !sel_match) |=> (lstate_r == adc_i2c_pkg::L_SKIP);
  endproperty
  a_sel_pins: assert property (p_sel_pins) else $error("select bits mismatch not refused");

  property p_dir;
    @(posedge SCL) disable iff (!RESETN)
      (lstate_r == adc_i2c_pkg::L_ADDR_ACK && !start_det_r) |=>
        (lstate_r == ($past(rw_r) ? adc_i2c_pkg::L_RD : adc_i2c_pkg::L_WR));
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit decoded wrongly");

  property p_addr_ack;
    @(posedge SCL) disable iff (!RESETN)
      (lstate_r == adc_i2c_pkg::L_ADDR_ACK) |-> (SDA_OE && !SDA_OUT);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

  sequence s_byte_in;
    cmd_take;
  endsequence
  property p_wr_ack;
    @(posedge SCL) disable iff (!RESETN)
      s_byte_in |=> (lstate_r == adc_i2c_pkg::L_WR_ACK) && SDA_OE;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");

  property p_release;
    @(posedge SCL) disable iff (!RESETN)
      (lstate_r == adc_i2c_pkg::L_RD_ACK && SDA_IN && !start_det_r) |=> !SDA_OE;
  endproperty
  a_release: assert property (p_release) else $error("SDA held after NACK");

  property p_skip;
    @(posedge SCL) disable iff (!RESETN)
      (lstate_r == adc_i2c_pkg::L_SKIP) |-> !SDA_OE;
  endproperty
  a_skip: assert property (p_skip) else $error("SDA driven in ignored transfer");

  property p_pad_bits;
    @(negedge SCL) disable iff (!RESETN)
      (lstate_r == adc_i2c_pkg::L_RD && !byte_sel_r && bit_cnt_r < 3'h4) |=> SDA_OE;
  endproperty
  a_pad_bits: assert property (p_pad_bits) else $error("upper nibble of first byte not zero");

  property p_cmd_conv;
    @(posedge CLK) disable iff (!RESETN)
      (start_conv && hold_chan_ok) |=> (cstate_r == adc_i2c_pkg::C_WAIT) && CONV_POWER && CONV_CLK_EN;
  endproperty
  a_cmd_conv: assert property (p_cmd_conv) else $error("command did not start conversion");

  property p_bad_chan;
    @(posedge CLK) disable iff (!RESETN)
      (start_conv && !hold_chan_ok) |=> (cstate_r == adc_i2c_pkg::C_IDLE);
  endproperty
  a_bad_chan: assert property (p_bad_chan) else $error("invalid channel converted");

  property p_ref_on;
    @(posedge CLK) disable iff (!RESETN)
      $rose(ref_on_r) |-> $past(bound_evt && ref_req_r);
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference enabled without bus boundary");

  sequence s_sar_run;
    (cstate_r == adc_i2c_pkg::C_SAR) [*8];
  endsequence
  property p_sar_len;
    @(posedge CLK) disable iff (!RESETN)
      $rose(cstate_r == adc_i2c_pkg::C_SAR) |-> s_sar_run ##22 (cstate_r == adc_i2c_pkg::C_SAR)
        ##1 (cstate_r == adc_i2c_pkg::C_IDLE);
  endproperty
  a_sar_len: assert property (p_sar_len) else $error("conversion length wrong");

  property p_clk_gate;
    @(posedge CLK) disable iff (!RESETN)
      (cstate_r == adc_i2c_pkg::C_SAR) |-> CONV_CLK_EN && CONV_POWER;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("core unpowered during conversion");
endmodule : adc_i2c_front
`default_nettype wire

// file: tb/adc_i2c_front_tb.sv
// Self-checking bench for the I2C converter front end
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_i2c_front_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] FCODE = 5'h0B; // Arbitrary value
  localparam logic [6:0] DEV = {FCODE, 2'b10};
  logic CLK = 1'b0;
  logic RESETN = 1'b1;
  logic comp_hi = 1'b0;
  logic [9:0] analog = 10'h2A5;
  logic scl, m_pull, sda, sda_oe, neg_is_com, sample, clk_en, conv_power, ref_power, busy;
  logic [9:0] dac_code;
  logic [2:0] mux_pos, mux_neg;
  int errors = 0;
  int checks_done = 0;
  int sample_cnt = 0;
  logic sda_oe4, busy4;
  // Open-drain wire with pull-up
  assign sda = ~(sda_oe | sda_oe4 | m_pull);
  // Counts cycles with SAMPLE high (power-up wait or acquisition), read only between conversions
  always @(negedge CLK) begin
    if (sample === 1'b1) begin
      sample_cnt++;
    end
  end
  always #10 CLK = ~CLK;
  // Comparator model follows the trial code, driven off the sampling edge
  always @(negedge CLK) comp_hi <= (analog >= dac_code);
  bus_master i_bus_master (.scl(scl), .sda_pull(m_pull), .sda(sda));
  adc_i2c_front #(.CHANNELS(8), .FIXED_CODE(FCODE)) i_adc_i2c_front (
    .CLK(CLK), .RESETN(RESETN), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
    .ADDR_SELECT_PIN_HI(1'b1), .ADDR_SELECT_PIN_LO(1'b0), .COMP_HI(comp_hi),
    .DAC_CODE(dac_code), .MUX_POS(mux_pos), .MUX_NEG(mux_neg), .NEG_IS_COM(neg_is_com),
    .SAMPLE(sample), .CONV_CLK_EN(clk_en), .CONV_POWER(conv_power), .REF_POWER(ref_power),
    .CONV_BUSY(busy));
  // Four-channel build on the same bus, strapped to the one select code nobody else uses
  adc_i2c_front #(.CHANNELS(4), .FIXED_CODE(FCODE)) i_adc_i2c_front_four (
    .CLK(CLK), .RESETN(RESETN), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe4),
    .ADDR_SELECT_PIN_HI(1'b0), .ADDR_SELECT_PIN_LO(1'b0), .COMP_HI(comp_hi),
    .DAC_CODE(), .MUX_POS(), .MUX_NEG(), .NEG_IS_COM(), .SAMPLE(), .CONV_CLK_EN(), .CONV_POWER(),
    .REF_POWER(), .CONV_BUSY(busy4));
  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // Bounded waits for the converter to start and then finish
  task automatic wait_conv();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 40) begin
      @(negedge CLK);
      n++;
    end
    `CHK(busy, 1'b1)
    n = 0;
    while (busy !== 1'b0 && n < 600) begin
      @(negedge CLK);
      n++;
    end
    `CHK(busy, 1'b0)
  endtask : wait_conv
  // Write transfer of one command byte, closed by STOP
  task automatic send_cmd(input logic [7:0] cmd);
    logic a0, a1;
    i_bus_master.start();
    i_bus_master.wr_byte({DEV, 1'b0}, a0);
    i_bus_master.wr_byte(cmd, a1);
    i_bus_master.stop();
    `CHK(a0, 1'b1)
    `CHK(a1, 1'b1)
  endtask : send_cmd
  task automatic t_reset();
    `CHK(ref_power, 1'b0)
    `CHK(sda_oe, 1'b0)
    `CHK(sda_oe4, 1'b0)
    `CHK(clk_en, 1'b0)
  endtask : t_reset
  // Wrong code or wrong select bits: no answer, and the command is dropped
  task automatic t_refuse();
    logic [7:0] bad [3] = '{{FCODE ^ 5'h01, 3'b100}, {FCODE, 3'b010}, {FCODE, 3'b110}};
    logic a0, a1;
    foreach (bad[k]) begin
      i_bus_master.start();
      i_bus_master.wr_byte(bad[k], a0);
      i_bus_master.wr_byte(8'hFC, a1);
      i_bus_master.stop();
      repeat (10) @(negedge CLK);
      `CHK(a0, 1'b0)
      `CHK(a1, 1'b0)
      `CHK({busy, ref_power}, 2'b00)
    end
  endtask : t_refuse
  // Every mode and channel code, converter power bit varied, low bits set
  task automatic t_channels();
    logic [3:0] c;
    logic p;
    int s0;
    p = 1'b0;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      s0 = sample_cnt;
      send_cmd({c, 1'b0, ^c, 2'b11});
      wait_conv();
      // Power state follows the mode one cycle after the conversion ends
      repeat (2) @(negedge CLK);
      `CHK(sample_cnt - s0, (p ? adc_i2c_pkg::SAMPLE_CYC : adc_i2c_pkg::PWRUP_CYC) + 1)
      p = ^c;
      `CHK(neg_is_com, c[3])
      `CHK(mux_pos, {c[1:0], c[2]})
      if (c[3] == 1'b0) begin
        `CHK(mux_neg, {c[1:0], ~c[2]})
      end
      `CHK(conv_power, ^c)
      `CHK(clk_en, 1'b0)
    end
  endtask : t_channels
  // Convert, then read three bytes; the third wraps back to the first
  task automatic t_read(input logic [9:0] v);
    logic a;
    logic [7:0] b0, b1, b2;
    analog = v;
    send_cmd(8'h84);
    wait_conv();
    i_bus_master.start();
    i_bus_master.wr_byte({DEV, 1'b1}, a);
    i_bus_master.rd_byte(b0, 1'b1);
    i_bus_master.rd_byte(b1, 1'b1);
    i_bus_master.rd_byte(b2, 1'b0);
    #5;
    `CHK(sda_oe, 1'b0)
    i_bus_master.stop();
    `CHK(a, 1'b1)
    `CHK(b0, {4'h0, v[9:6]})
    `CHK(b1, {v[5:0], 2'b00})
    `CHK(b2, {4'h0, v[9:6]})
  endtask : t_read
  // Reference turns on only at STOP or repeated START, off at once
  task automatic t_ref();
    logic a;
    i_bus_master.start();
    i_bus_master.wr_byte({DEV, 1'b0}, a);
    i_bus_master.wr_byte(8'h88, a);
    repeat (8) @(negedge CLK);
    `CHK(ref_power, 1'b0)
    i_bus_master.start();
    repeat (8) @(negedge CLK);
    `CHK(ref_power, 1'b1)
    i_bus_master.wr_byte({DEV, 1'b0}, a);
    i_bus_master.wr_byte(8'h80, a);
    repeat (8) @(negedge CLK);
    `CHK(ref_power, 1'b0)
    i_bus_master.stop();
    wait_conv();
    send_cmd(8'h8C);
    repeat (8) @(negedge CLK);
    `CHK(ref_power, 1'b1)
    wait_conv();
  endtask : t_ref
  // Four-channel build acks a high-channel command but converts only a low one
  task automatic t_four();
    logic a0, a1;
    logic [7:0] cmd [2] = '{8'hA4, 8'h94};
    foreach (cmd[k]) begin
      i_bus_master.start();
      i_bus_master.wr_byte({FCODE, 3'b000}, a0);
      i_bus_master.wr_byte(cmd[k], a1);
      i_bus_master.stop();
      repeat (20) @(negedge CLK);
      `CHK({a0, a1}, 2'b11)
      `CHK(busy4, k[0])
    end
  endtask : t_four
  // Reset falls on an edge so the SCL-side flops, which see no clock yet, are cleared too
  initial begin
    @(negedge CLK) RESETN = 1'b0;
    repeat (12) @(posedge CLK);
    @(negedge CLK) RESETN = 1'b1;
    repeat (6) @(negedge CLK);
    t_reset();
    t_refuse();
    t_channels();
    t_read(10'h2A5);
    t_read(10'h15A);
    t_read(10'h3FF);
    t_read(10'h000);
    t_ref();
    t_four();
    final_report();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    errors++;
    final_report();
  end
endmodule : adc_i2c_front_tb
`default_nettype wire

// file: tb/bus_master.sv
// Behavioural I2C bus master that drives SCL and pulls SDA low
`default_nettype none
module bus_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 24ns;
  // SCL stands high between frames, so the bus starts idle
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Data moves only mid-low, so SDA never changes while SCL is high
  task automatic put_bit(input logic b);
    #(HALF / 2) sda_pull = ~b;
    #(HALF / 2) scl = 1'b1;
    #HALF scl = 1'b0;
  endtask : put_bit
  // Releases SDA and samples it in the middle of the high phase
  task automatic get_bit(output logic b);
    #(HALF / 2) sda_pull = 1'b0;
    #(HALF / 2) scl = 1'b1;
    #(HALF / 2) b = sda;
    #(HALF / 2) scl = 1'b0;
  endtask : get_bit
  // Begins only from an idle bus, or re-starts while still owning it
  task automatic start();
    if (scl == 1'b0) begin
      #(HALF / 2) sda_pull = 1'b0;
      #(HALF / 2) scl = 1'b1;
      #HALF;
    end
    sda_pull = 1'b1;
    #HALF scl = 1'b0;
  endtask : start
  // SDA rises while SCL is high, then the bus is idle again
  task automatic stop();
    #(HALF / 2) sda_pull = 1'b1;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_pull = 1'b0;
    #HALF;
  endtask : stop
  // Eight data bits, then a ninth pulse for the slave's answer
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(s);
    ack = ~s;
  endtask : wr_byte
  // Master acknowledges all but the last byte it takes
  task automatic rd_byte(output logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b[i]);
    end
    put_bit(~ack);
  endtask : rd_byte
endmodule : bus_master
`default_nettype wire
